//--- src/port_pins_regs.vh
/*
 * constants for the port 12/13/14 pin logic: apb offsets, field
 * positions, reset values and edge select codes.
 * assumes a 32-bit apb slave with word-aligned registers.
 */
`ifndef PORT_PINS_REGS_VH
`define PORT_PINS_REGS_VH

// ==================================================
// register offsets (byte addresses)
`define OFS_P12_DATA 12'h000
`define OFS_P13_DATA 12'h004
`define OFS_P14_DATA 12'h008
`define OFS_P12_DIR 12'h00c
`define OFS_P14_DIR 12'h010
`define OFS_P12_PU 12'h014
`define OFS_P14_PU 12'h018
`define OFS_P12_CTRL 12'h01c
`define OFS_P14_CTRL 12'h020
`define OFS_IRQ_EDGE 12'h024
`define OFS_IRQ_STAT 12'h028
`define OFS_IRQ_MASK 12'h02c

// ==================================================
// reset values
`define RST_DIR12 1'h1
`define RST_DIR14 2'h3
`define RST_PORT12_PULLUP_REG 1'h0
`define RST_PORT14_PULLUP_REG 2'h0
`define RST_CTRL12 5'h00
`define RST_CTRL14 2'h0
`define RST_EDGE 4'h0
`define RST_MASK 2'h0

// ==================================================
// edge select codes, two bits per irq
`define EDGE_NONE 2'h0
`define EDGE_RISE 2'h1
`define EDGE_FALL 2'h2
`define EDGE_BOTH 2'h3

// ==================================================
// fields of the edge register and status bits
`define EDGE_A_LSB 0
`define EDGE_B_LSB 2
`define IRQ_A_BIT 0
`define IRQ_B_BIT 1

// ==================================================
// port14 control bits
`define CTRL14_CLK_OUT 0
`define CTRL14_BUZ_OUT 1

`endif

//--- src/edge_detect.v
/*
 * edge detector for one external interrupt input with a selectable
 * valid edge. assumes the input is already synchronised to sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "port_pins_regs.vh"

module edge_detect (
    input wire sys_clk,
    input wire sys_rst,
    input wire sig_in,
    input wire [1:0] edge_sel,
    output wire edge_pulse
);

reg prev_r;

always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
        prev_r <= 1'b0;
    end else begin
        prev_r <= sig_in;
    end
end

// rising, falling or both, per selection
assign edge_pulse = ((edge_sel == `EDGE_RISE) && sig_in && !prev_r) ||
                    ((edge_sel == `EDGE_FALL) && !sig_in && prev_r) ||
                    ((edge_sel == `EDGE_BOTH) && (sig_in != prev_r));

endmodule
`default_nettype wire

//--- src/port_pins.v
/*
 * port 12, 13 and 14 pin logic with apb register access and an
 * interrupt for the two external edge inputs.
 * assumes pad buffers outside resolve the output enables and pull-ups;
 * pin inputs are asynchronous and are synchronised here.
 */
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "port_pins_regs.vh"

module port_pins (
    input wire sys_clk,
    input wire sys_rst,
    input wire reset_pin_n,
    output wire sys_reset_req,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    output wire irq,
    input wire port12_bit0_in,
    output wire port12_bit0_out,
    output wire port12_bit0_oe,
    output wire port12_bit0_pu,
    input wire [3:0] port12_hi_in,
    output wire port13_out_bit,
    input wire port14_bit0_in,
    output wire port14_bit0_out,
    output wire port14_bit0_oe,
    output wire port14_bit0_pu,
    input wire port14_bit1_in,
    output wire port14_bit1_out,
    output wire port14_bit1_oe,
    output wire port14_bit1_pu,
    input wire clock_out_sig,
    input wire buzzer_out_sig,
    output wire ext_irq_a,
    output wire ext_irq_b,
    output wire ext_low_voltage_in,
    output wire ext_main_clock_in,
    output wire main_osc_sel,
    output wire sub_osc_sel,
    output wire remote_rx_in
);

// ==================================================
// reset pin synchroniser
reg rst_s1_r;
reg rst_s2_r;

always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
        // idle level of the pin, so no request right after reset
        rst_s1_r <= 1'h1;
        rst_s2_r <= 1'h1;
    end else begin
        rst_s1_r <= reset_pin_n;
        rst_s2_r <= rst_s1_r;
    end
end

// low pin requests system reset
assign sys_reset_req = !rst_s2_r;

// ==================================================
// pin input synchronisers
wire [6:0] pin_raw;
reg [6:0] pin_s1_r;
reg [6:0] pin_s2_r;

assign pin_raw = {port14_bit1_in, port14_bit0_in, port12_hi_in,
                  port12_bit0_in};

always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
        pin_s1_r <= 7'h00;
        pin_s2_r <= 7'h00;
    end else begin
        pin_s1_r <= pin_raw;
        pin_s2_r <= pin_s1_r;
    end
end

// ==================================================
// registers
reg p12_data_r;
reg p13_data_r;
reg [1:0] p14_data_r;
reg p12_dir_r;
reg [1:0] p14_dir_r;
reg p12_pu_r;
reg [1:0] p14_pu_r;
reg [4:0] p12_ctrl_r;
reg [1:0] p14_ctrl_r;
reg [3:0] edge_r;
reg [1:0] stat_r;
reg [1:0] mask_r;
wire [1:0] irq_evt;

wire wr_en;
wire rd_sel;
reg addr_ok;

assign wr_en = psel && penable && pwrite;
assign rd_sel = psel && !pwrite;
assign pready = 1'b1;
assign pslverr = psel && penable && !addr_ok;

always @* begin
    case (paddr)
        `OFS_P12_DATA, `OFS_P13_DATA, `OFS_P14_DATA, `OFS_P12_DIR,
        `OFS_P14_DIR, `OFS_P12_PU, `OFS_P14_PU, `OFS_P12_CTRL,
        `OFS_P14_CTRL, `OFS_IRQ_EDGE, `OFS_IRQ_STAT,
        `OFS_IRQ_MASK: begin
            addr_ok = 1'b1;
        end
        default: begin
            addr_ok = 1'b0;
        end
    endcase
end

// port data and direction registers
always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
        p12_data_r <= 1'h0;
        p14_data_r <= 2'h0;
        p12_dir_r <= `RST_DIR12;
        p14_dir_r <= `RST_DIR14;
    end else if (wr_en) begin
        case (paddr)
            `OFS_P12_DATA: p12_data_r <= pwdata[0];
            `OFS_P14_DATA: p14_data_r <= pwdata[1:0];
            `OFS_P12_DIR: p12_dir_r <= pwdata[0];
            `OFS_P14_DIR: p14_dir_r <= pwdata[1:0];
            default: begin
            end
        endcase
    end
end

// port13 latch kept apart: its reset level is what the board sees
always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
        p13_data_r <= 1'h0;
    end else if (wr_en && paddr == `OFS_P13_DATA) begin
        p13_data_r <= pwdata[0];
    end
end

// pull-up and function select registers
always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
        p12_pu_r <= `RST_PORT12_PULLUP_REG;
        p14_pu_r <= `RST_PORT14_PULLUP_REG;
        p12_ctrl_r <= `RST_CTRL12;
        p14_ctrl_r <= `RST_CTRL14;
    end else if (wr_en) begin
        case (paddr)
            `OFS_P12_PU: p12_pu_r <= pwdata[0];
            `OFS_P14_PU: p14_pu_r <= pwdata[1:0];
            `OFS_P12_CTRL: p12_ctrl_r <= pwdata[4:0];
            `OFS_P14_CTRL: p14_ctrl_r <= pwdata[1:0];
            default: begin
            end
        endcase
    end
end

// interrupt edge and mask registers
always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
        edge_r <= `RST_EDGE;
        mask_r <= `RST_MASK;
    end else if (wr_en) begin
        case (paddr)
            `OFS_IRQ_EDGE: edge_r <= pwdata[3:0];
            `OFS_IRQ_MASK: mask_r <= pwdata[1:0];
            default: begin
            end
        endcase
    end
end

// sticky status, set wins over write-one-to-clear
wire [1:0] stat_clr;
assign stat_clr = (wr_en && paddr == `OFS_IRQ_STAT) ? pwdata[1:0] : 2'h0;

always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
        stat_r <= 2'h0;
    end else begin
        stat_r <= (stat_r & ~stat_clr) | irq_evt;
    end
end

assign irq = |(stat_r & mask_r);

// ==================================================
// read mux; data reads return pin level for inputs
wire p12_rd;
wire [1:0] p14_rd;
assign p12_rd = p12_dir_r ? pin_s2_r[0] : p12_data_r;
assign p14_rd = (p14_dir_r & pin_s2_r[6:5]) | (~p14_dir_r & p14_data_r);

reg [31:0] rd_word_nxt;

// word for the addressed register; unmapped offsets read zero
always @* begin
    rd_word_nxt = 32'h00000000;
    case (paddr)
        `OFS_P12_DATA: rd_word_nxt = {27'h0, pin_s2_r[4:1], p12_rd};
        `OFS_P13_DATA: rd_word_nxt = {31'h0, p13_data_r};
        `OFS_P14_DATA: rd_word_nxt = {30'h0, p14_rd};
        `OFS_P12_DIR: rd_word_nxt = {31'h0, p12_dir_r};
        `OFS_P14_DIR: rd_word_nxt = {30'h0, p14_dir_r};
        `OFS_P12_PU: rd_word_nxt = {31'h0, p12_pu_r};
        `OFS_P14_PU: rd_word_nxt = {30'h0, p14_pu_r};
        `OFS_P12_CTRL: rd_word_nxt = {27'h0, p12_ctrl_r};
        `OFS_P14_CTRL: rd_word_nxt = {30'h0, p14_ctrl_r};
        `OFS_IRQ_EDGE: rd_word_nxt = {28'h0, edge_r};
        `OFS_IRQ_STAT: rd_word_nxt = {30'h0, stat_r};
        `OFS_IRQ_MASK: rd_word_nxt = {30'h0, mask_r};
        default: rd_word_nxt = 32'h00000000;
    endcase
end

// latched in the setup cycle, held until the next read setup
always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
        prdata <= 32'h00000000;
    end else if (rd_sel && !penable) begin
        prdata <= rd_word_nxt;
    end
end

// ==================================================
// port 12 pins
assign port12_bit0_out = p12_data_r;
assign port12_bit0_oe = !p12_dir_r && !p12_ctrl_r[0];
assign port12_bit0_pu = p12_pu_r && p12_dir_r;
// bits 1-4 have no driver at all
assign ext_irq_a = p12_ctrl_r[0] & pin_s2_r[0];
assign ext_low_voltage_in = p12_ctrl_r[0] & pin_s2_r[0];
assign main_osc_sel = p12_ctrl_r[1] & p12_ctrl_r[2];
assign ext_main_clock_in = p12_ctrl_r[2] & pin_s2_r[2];
assign sub_osc_sel = p12_ctrl_r[3] & p12_ctrl_r[4];

// ==================================================
// port 13 pin, output only
assign port13_out_bit = p13_data_r;

// ==================================================
// port 14 pins
wire [1:0] p14_periph;
wire [1:0] p14_out_w;
wire [1:0] p14_oe_w;
wire [1:0] p14_pu_w;
genvar gi;

// peripheral output per bit, ordered as the control bits
assign p14_periph[`CTRL14_CLK_OUT] = clock_out_sig;
assign p14_periph[`CTRL14_BUZ_OUT] = buzzer_out_sig;

generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_p14_bit
        assign p14_out_w[gi] = p14_ctrl_r[gi] ? p14_periph[gi] :
                               p14_data_r[gi];
        assign p14_oe_w[gi] = !p14_dir_r[gi];
        // pull-up only on an input, never against the driver
        assign p14_pu_w[gi] = p14_pu_r[gi] && p14_dir_r[gi];
    end
endgenerate

assign port14_bit0_out = p14_out_w[0];
assign port14_bit1_out = p14_out_w[1];
assign port14_bit0_oe = p14_oe_w[0];
assign port14_bit1_oe = p14_oe_w[1];
assign port14_bit0_pu = p14_pu_w[0];
assign port14_bit1_pu = p14_pu_w[1];
assign ext_irq_b = !p14_ctrl_r[0] & pin_s2_r[5];
assign remote_rx_in = !p14_ctrl_r[0] & pin_s2_r[5];

// ==================================================
// edge detection for the two external irqs
edge_detect u_edge_a (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .sig_in(ext_irq_a),
    .edge_sel(edge_r[`EDGE_A_LSB+1:`EDGE_A_LSB]),
    .edge_pulse(irq_evt[`IRQ_A_BIT])
);

edge_detect u_edge_b (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .sig_in(ext_irq_b),
    .edge_sel(edge_r[`EDGE_B_LSB+1:`EDGE_B_LSB]),
    .edge_pulse(irq_evt[`IRQ_B_BIT])
);

endmodule
`default_nettype wire

//--- tb/pin_model.sv
/* board side of one two-way port pin.
   assumes the bench chooses to drive it or leave it open. */
`timescale 1ns/1ps
`default_nettype none
module pin_model (
    input wire logic oe,
    input wire logic o,
    input wire logic pu,
    input wire logic de,
    input wire logic dv,
    output var logic pin
);
initial pin = 1'b0;
// open pin without pull-up flips, so a stale level never passes
always @(oe or o or pu or de or dv) begin
    if (oe)
        pin = o;
    else if (de)
        pin = dv;
    else if (pu)
        pin = 1'b1;
    else
        pin = ~pin;
end
endmodule
`default_nettype wire

//--- tb/port_pins_properties.sv
/* assertions on the port pin block's top ports.
   assumes one clock and sys_rst async active high. */
`timescale 1ns/1ps
`default_nettype none
module port_pins_properties (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic reset_pin_n,
    input wire logic sys_reset_req,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic irq,
    input wire logic port12_bit0_oe,
    input wire logic port12_bit0_pu,
    input wire logic port13_out_bit,
    input wire logic port14_bit0_oe,
    input wire logic port14_bit0_pu,
    input wire logic port14_bit1_oe,
    input wire logic port14_bit1_pu
);
// ====
// properties
default clocking @(posedge sys_clk); endclocking
default disable iff (sys_rst);
wire wr = psel && penable && pwrite;
wire rs = psel && !penable && !pwrite;
sequence s_lo; !reset_pin_n [*4]; endsequence
sequence s_hi; reset_pin_n [*4]; endsequence
property p_rd; !rs |=> $stable(prdata); endproperty
a_rd: assert property (p_rd) else $error("read data moved");
property p_irq; irq && !wr |=> irq; endproperty
a_irq: assert property (p_irq) else $error("irq dropped");
property p_port12_pullup_reg; port12_bit0_pu |-> !port12_bit0_oe; endproperty
a_port12_pullup_reg: assert property (p_port12_pullup_reg) else $error("pull-up on output");
property p_port14_pullup_reg;
    !(port14_bit0_pu && port14_bit0_oe || port14_bit1_pu && port14_bit1_oe);
endproperty
a_port14_pullup_reg: assert property (p_port14_pullup_reg) else $error("pull-up on output");
property p_cfg;
    !wr |=> $stable({port12_bit0_oe, port14_bit0_oe, port14_bit1_oe,
        port13_out_bit});
endproperty
a_cfg: assert property (p_cfg) else $error("config moved");
property p_p13; $fell(sys_rst) |-> !port13_out_bit; endproperty
a_p13: assert property (p_p13) else $error("port13 high");
property p_on; s_lo |-> sys_reset_req; endproperty
a_on: assert property (p_on) else $error("no reset req");
property p_off; s_hi |-> !sys_reset_req; endproperty
a_off: assert property (p_off) else $error("stray reset req");
endmodule
bind port_pins port_pins_properties chk (.sys_clk, .sys_rst, .reset_pin_n,
    .sys_reset_req, .psel, .penable, .pwrite, .prdata, .irq,
    .port12_bit0_oe, .port12_bit0_pu, .port13_out_bit, .port14_bit0_oe,
    .port14_bit0_pu, .port14_bit1_oe, .port14_bit1_pu);
`default_nettype wire

//--- tb/port_pins_tb.sv
/* bench for port_pins: apb tasks, pin models, checks.
   assumes pin_model and the checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`include "port_pins_regs.vh"
module port_pins_tb;
logic sys_clk = 0, sys_rst = 1, rst_n = 1, cs = 0, bz = 0, er = 0;
logic psel = 0, penable = 0, pwrite = 0;
logic [11:0] paddr = 0;
logic [31:0] pwdata = 0, q;
logic [3:0] hi = 0;
logic [2:0] den = 0, dv = 0;
wire [31:0] prdata;
wire pready, irq, req, p13, mo, so, ea, lv, mc, perr, eb, rr;
wire [2:0] oe, out, pu, pin;
int n_mismatch = 0, checks_done = 0, k, c;
always #5 sys_clk = ~sys_clk;
port_pins uut (.sys_clk, .sys_rst, .reset_pin_n(rst_n),
    .sys_reset_req(req), .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr(perr), .irq, .port12_bit0_in(pin[0]),
    .port12_bit0_out(out[0]), .port12_bit0_oe(oe[0]),
    .port12_bit0_pu(pu[0]), .port12_hi_in(hi), .port13_out_bit(p13),
    .port14_bit0_in(pin[1]), .port14_bit0_out(out[1]),
    .port14_bit0_oe(oe[1]), .port14_bit0_pu(pu[1]),
    .port14_bit1_in(pin[2]), .port14_bit1_out(out[2]),
    .port14_bit1_oe(oe[2]), .port14_bit1_pu(pu[2]), .clock_out_sig(cs),
    .buzzer_out_sig(bz), .ext_irq_a(ea), .ext_irq_b(eb),
    .ext_low_voltage_in(lv), .ext_main_clock_in(mc), .main_osc_sel(mo),
    .sub_osc_sel(so), .remote_rx_in(rr));
pin_model pm[2:0] (.oe(oe), .o(out), .pu(pu), .de(den), .dv(dv),
    .pin(pin));
// ====
// tasks
task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
        n_mismatch++;
        $display("wrong value at %0t: %h vs %h", $time, g, e);
    end
endtask
task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    er = perr;
    psel <= 0;
    penable <= 0;
    repeat (3) @(posedge sys_clk);
endtask
task rd(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk(q, e);
endtask
task test_done;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
        $display("ALL CHECKS OK");
    else
        $display("CHECKS NOT OK");
    $finish;
endtask
// ====
// tests
initial begin
    repeat (6) @(posedge sys_clk);
    sys_rst <= 0;
    @(posedge sys_clk);
    rd(`OFS_P12_DIR, 1);
    rd(`OFS_P14_DIR, 3);
    rd(`OFS_P14_PU, 0);
    chk(er, 0);
    rd(12'hffc, 0);
    chk(er, 1);
    chk(p13, 0);
    chk({mo, so, mc, ea, lv}, 0);
    apb(1, `OFS_P12_PU, 1);
    rd(`OFS_P12_DATA, 1);
    hi <= 4'ha;
    apb(1, `OFS_P12_DIR, 32'h1e);
    chk({oe[0], pu[0]}, 2);
    rd(`OFS_P12_DIR, 0);
    apb(1, `OFS_P12_DATA, 1);
    chk(out[0], 1);
    rd(`OFS_P12_DATA, 32'h15);
    apb(1, `OFS_P13_DATA, 1);
    chk(p13, 1);
    apb(1, `OFS_P14_PU, 3);
    apb(1, `OFS_P14_DIR, 2);
    chk({oe[2:1], pu[2:1]}, 6);
    apb(1, `OFS_P14_DIR, 0);
    apb(1, `OFS_P14_DATA, 3);
    apb(1, `OFS_P14_CTRL, 3);
    chk(out[2:1], 0);
    {bz, cs} <= 2'b11;
    repeat (2) @(posedge sys_clk);
    chk(out[2:1], 3);
    chk({eb, rr}, 0);
    {bz, cs} <= 0;
    apb(1, `OFS_P14_CTRL, 0);
    chk(out[2:1], 3);
    {den, dv} <= 6'b001001;
    hi <= 4'h2;
    apb(1, `OFS_P12_CTRL, 32'h1f);
    chk({mo, so, mc, ea, lv, eb, rr}, 7'h7f);
    apb(1, `OFS_P12_DIR, 1);
    apb(1, `OFS_P14_DIR, 3);
    apb(1, `OFS_P12_CTRL, 1);
    den <= 3'b011;
    dv <= 0;
    apb(1, `OFS_IRQ_MASK, 3);
    for (k = 0; k < 2; k++)
        for (c = 0; c < 4; c++) begin
            apb(1, `OFS_IRQ_EDGE, c << (2 * k));
            apb(1, `OFS_IRQ_STAT, 3);
            dv[k] <= 1;
            repeat (4) @(posedge sys_clk);
            rd(`OFS_IRQ_STAT, (c & 1) << k);
            chk(irq, c & 1);
            apb(1, `OFS_IRQ_STAT, 3);
            dv[k] <= 0;
            repeat (4) @(posedge sys_clk);
            rd(`OFS_IRQ_STAT, (c >> 1) << k);
        end
    apb(1, `OFS_IRQ_MASK, 1);
    chk(irq, 0);
    apb(1, `OFS_IRQ_MASK, 2);
    chk(irq, 1);
    apb(1, `OFS_IRQ_STAT, 2);
    chk(irq, 0);
    rst_n <= 0;
    repeat (5) @(posedge sys_clk);
    chk(req, 1);
    rst_n <= 1;
    repeat (5) @(posedge sys_clk);
    chk(req, 0);
    sys_rst <= 1;
    @(posedge sys_clk);
    chk(p13, 0);
    test_done;
end
initial begin
    repeat (5000) @(posedge sys_clk);
    n_mismatch++;
    test_done;
end
endmodule
`default_nettype wire
